// ==== logic/ssp_pkg.sv ====
// Constants shared by the serial programming port
package ssp_pkg;
  localparam int SHIFT_W = 21;
  localparam int CTRL_W = 2;
  localparam int NUM_LATCH = 3;
  localparam logic [1:0] SEL_LATCH0 = 2'h0;
  localparam logic [1:0] SEL_LATCH1 = 2'h1;
  localparam logic [1:0] SEL_LATCH2 = 2'h2;
  localparam int PD_POS = 3;
  localparam int MUX_POS = 4;
  localparam logic [1:0] MUX_LOCK = 2'h0;
  localparam logic [1:0] MUX_REF = 2'h1;
  localparam logic [1:0] MUX_RF = 2'h2;
  localparam logic [20:0] LATCH_RESET = 21'h000000;
  localparam int SYNC_STAGES = 2;
endpackage

// ==== logic/ssp_sync.sv ====
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module ssp_sync #(
  parameter int WIDTH = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage1;

  // ****************************************
  // Synchroniser stages
  // ****************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      stage1 <= '0;
      dout <= '0;
    end
    else
    begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule

// ==== logic/ssp_port.sv ====
// Serial programming port of a frequency synthesizer
// Summary of operation
// RL1: Shift data on serial clock rise, 21 bits
// RL2: Host sends words most significant bit first
// RL3: Last two bits select destination latch
// RL4: Strobe rise copies word into chosen latch
// RL5: Enable low: powered down, pump tri-stated
// RL6: Enable high powers up unless powerdown bit
// RL7: Monitor output muxes dividers or lock detect
// RL8: Host keeps strobe low while shifting
`timescale 1ns/10ps
module ssp_port (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic SER_CLK,
  input wire logic SER_DATA,
  input wire logic LATCH_LOAD_STROBE,
  input wire logic CHIP_POWER_ENABLE,
  input wire logic RF_DIV_IN,
  input wire logic REF_DIV_IN,
  input wire logic LOCK_DETECT_IN,
  output logic [ssp_pkg::SHIFT_W-1:0] LATCH0,
  output logic [ssp_pkg::SHIFT_W-1:0] LATCH1,
  output logic [ssp_pkg::SHIFT_W-1:0] LATCH2,
  output logic POWERED_UP,
  output logic PUMP_OUTPUT_EN,
  output logic DIVIDER_LOCK_MONITOR_OUT
);
  logic [2:0] pins_s;
  logic sclk_s;
  logic data_s;
  logic strobe_s;
  logic sclk_d;
  logic strobe_d;
  logic enable_q1;
  logic enable_s;
  logic sclk_rise;
  logic strobe_rise;
  logic powerdown_control_bit;
  logic [1:0] mon_sel;
  logic [ssp_pkg::SHIFT_W-1:0] shreg;

  // ****************************************
  // Pin synchronisation
  // ****************************************
  ssp_sync #(
    .WIDTH(3)
  ) u_sync (
    .clk(MCLK),
    .rst(RST),
    .din({SER_CLK, SER_DATA, LATCH_LOAD_STROBE}),
    .dout(pins_s)
  );

  assign sclk_s = pins_s[2];
  assign data_s = pins_s[1];
  assign strobe_s = pins_s[0];

  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      enable_q1 <= 1'h0;
      enable_s <= 1'h0;
    end
    else
    begin
      enable_q1 <= CHIP_POWER_ENABLE;
      enable_s <= enable_q1;
    end
  end

  // ****************************************
  // Edge detection
  // ****************************************
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      sclk_d <= 1'h0;
      strobe_d <= 1'h0;
    end
    else
    begin
      sclk_d <= sclk_s;
      strobe_d <= strobe_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_d;
  assign strobe_rise = strobe_s & ~strobe_d;

  // ****************************************
  // Shift register
  // ****************************************
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
      shreg <= ssp_pkg::LATCH_RESET;
    else if (sclk_rise)
      shreg <= {shreg[ssp_pkg::SHIFT_W-2:0], data_s}; // RL1 RL2
  end

  // ****************************************
  // Latch load
  // ****************************************
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      LATCH0 <= ssp_pkg::LATCH_RESET;
      LATCH1 <= ssp_pkg::LATCH_RESET;
      LATCH2 <= ssp_pkg::LATCH_RESET;
    end
    else if (strobe_rise) // RL4 RL8
    begin
      case (shreg[ssp_pkg::CTRL_W-1:0]) // RL3
        ssp_pkg::SEL_LATCH0: LATCH0 <= shreg;
        ssp_pkg::SEL_LATCH1: LATCH1 <= shreg;
        ssp_pkg::SEL_LATCH2: LATCH2 <= shreg;
        default: ;
      endcase
    end
  end

  assign powerdown_control_bit = LATCH2[ssp_pkg::PD_POS];
  assign mon_sel = LATCH2[ssp_pkg::MUX_POS+1:ssp_pkg::MUX_POS];

  // ****************************************
  // Power control
  // ****************************************
  // Powered only while enabled and not held down by the control bit
  function automatic logic power_allowed(input logic en, input logic pd);
    return en & ~pd;
  endfunction

  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      POWERED_UP <= 1'h0;
      PUMP_OUTPUT_EN <= 1'h0;
    end
    else
    begin
      POWERED_UP <= power_allowed(enable_s, powerdown_control_bit); // RL5 RL6
      PUMP_OUTPUT_EN <= power_allowed(enable_s, powerdown_control_bit); // RL5 RL6
    end
  end

  // ****************************************
  // Monitor output
  // ****************************************
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
      DIVIDER_LOCK_MONITOR_OUT <= 1'h0;
    else
    begin
      case (mon_sel) // RL7
        ssp_pkg::MUX_LOCK: DIVIDER_LOCK_MONITOR_OUT <= LOCK_DETECT_IN;
        ssp_pkg::MUX_REF: DIVIDER_LOCK_MONITOR_OUT <= REF_DIV_IN;
        ssp_pkg::MUX_RF: DIVIDER_LOCK_MONITOR_OUT <= RF_DIV_IN;
        default: DIVIDER_LOCK_MONITOR_OUT <= 1'h0;
      endcase
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence load_to_latch0_s;
    strobe_rise && shreg[1:0] == ssp_pkg::SEL_LATCH0;
  endsequence

  sequence load_to_latch1_s;
    strobe_rise && shreg[1:0] == ssp_pkg::SEL_LATCH1;
  endsequence

  sequence load_to_latch2_s;
    strobe_rise && shreg[1:0] == ssp_pkg::SEL_LATCH2;
  endsequence

  shift_in_a: assert property (@(posedge MCLK) disable iff (RST) // RL1
    sclk_rise |=> shreg == {$past(shreg[19:0]), $past(data_s)})
    else $error("Shift register did not take serial bit");

  shift_hold_a: assert property (@(posedge MCLK) disable iff (RST) // RL1
    !sclk_rise |=> $stable(shreg))
    else $error("Shift register moved without clock edge");

  load_l0_a: assert property (@(posedge MCLK) disable iff (RST) // RL4
    load_to_latch0_s |=> LATCH0 == $past(shreg) && $stable(LATCH1))
    else $error("Latch 0 not loaded from shift register");

  load_l2_a: assert property (@(posedge MCLK) disable iff (RST) // RL3
    load_to_latch2_s |=> LATCH2 == $past(shreg) && $stable(LATCH0))
    else $error("Latch 2 not loaded from shift register");

  no_load_a: assert property (@(posedge MCLK) disable iff (RST) // RL3
    (!strobe_rise || shreg[1:0] == 2'h3) |=> $stable(LATCH0) && $stable(LATCH1)
      && $stable(LATCH2))
    else $error("Latch changed without valid load");

  pump_off_a: assert property (@(posedge MCLK) disable iff (RST) // RL5
    !enable_s |=> !PUMP_OUTPUT_EN && !POWERED_UP)
    else $error("Pump enabled while chip disabled");

  power_up_a: assert property (@(posedge MCLK) disable iff (RST) // RL6
    enable_s && !powerdown_control_bit |=> POWERED_UP && PUMP_OUTPUT_EN)
    else $error("Device failed to power up");

  power_bit_a: assert property (@(posedge MCLK) disable iff (RST) // RL6
    powerdown_control_bit |=> !POWERED_UP)
    else $error("Powerdown bit ignored");

  monitor_a: assert property (@(posedge MCLK) disable iff (RST) // RL7
    mon_sel == ssp_pkg::MUX_RF |=> DIVIDER_LOCK_MONITOR_OUT == $past(RF_DIV_IN))
    else $error("Monitor output not following RF divider");

  load_l1_a: assert property (@(posedge MCLK) disable iff (RST) // RL4
    load_to_latch1_s |=> LATCH1 == $past(shreg) && $stable(LATCH2))
    else $error("Latch 1 not loaded from shift register");

  monitor_lock_a: assert property (@(posedge MCLK) disable iff (RST) // RL7
    mon_sel == ssp_pkg::MUX_LOCK |=> DIVIDER_LOCK_MONITOR_OUT == $past(LOCK_DETECT_IN))
    else $error("Monitor output not following lock detect");

  monitor_ref_a: assert property (@(posedge MCLK) disable iff (RST) // RL7
    mon_sel == ssp_pkg::MUX_REF |=> DIVIDER_LOCK_MONITOR_OUT == $past(REF_DIV_IN))
    else $error("Monitor output not following reference divider");

  monitor_off_a: assert property (@(posedge MCLK) disable iff (RST) // RL7
    mon_sel == 2'h3 |=> !DIVIDER_LOCK_MONITOR_OUT)
    else $error("Monitor output not low for unused select");
endmodule

// ==== verif/ssp_host.sv ====
// Host model driving the serial programming pins
`timescale 1ns/10ps
module ssp_host (
  input wire logic clk,
  output logic ser_clk,
  output logic ser_data,
  output logic strobe
);
  initial
  begin
    ser_clk = 1'h0;
    ser_data = 1'h0;
    strobe = 1'h0;
  end
  task automatic send(input logic [20:0] w);
    for (int i = 20; i >= 0; i--)
    begin
      repeat (2) @(posedge clk);
      ser_data <= w[i];
      repeat (2) @(posedge clk);
      ser_clk <= 1'h1;
      repeat (4) @(posedge clk);
      ser_clk <= 1'h0;
    end
    repeat (2) @(posedge clk);
    ser_data <= ~w[0];
    strobe <= 1'h1;
    repeat (4) @(posedge clk);
    strobe <= 1'h0;
    repeat (4) @(posedge clk);
  endtask
endmodule

// ==== verif/tb.sv ====
// Self-checking bench for the serial programming port
`timescale 1ns/10ps
module tb;
  logic mclk, rst, sck, sda, stb, ce, rf, rfr, lk, pu, pen, mon;
  logic [20:0] l0, l1, l2;
  int n_fail = 0;
  int tests_run = 0;
  ssp_port DUT (.MCLK(mclk), .RST(rst), .SER_CLK(sck), .SER_DATA(sda),
    .LATCH_LOAD_STROBE(stb), .CHIP_POWER_ENABLE(ce), .RF_DIV_IN(rf), .REF_DIV_IN(rfr),
    .LOCK_DETECT_IN(lk), .LATCH0(l0), .LATCH1(l1), .LATCH2(l2), .POWERED_UP(pu),
    .PUMP_OUTPUT_EN(pen), .DIVIDER_LOCK_MONITOR_OUT(mon));
  ssp_host host (.clk(mclk), .ser_clk(sck), .ser_data(sda), .strobe(stb));
  initial
  begin
    mclk = 1'h0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic chk(input string nm, input logic [20:0] got, input logic [20:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic stop_test();
    if (n_fail == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic logic [20:0] mkw(input logic [1:0] mx, input logic pd, input logic [1:0] c);
    return {15'h6B3C ^ {13'h0, c}, mx, pd, 1'h1, c};
  endfunction
  // ********
  // Scenarios
  // ********
  task automatic t_load();
    for (int c = 0; c < 3; c++)
    begin
      host.send(mkw(2'h0, 1'h0, c[1:0]));
      chk("latch", c == 0 ? l0 : c == 1 ? l1 : l2, mkw(2'h0, 1'h0, c[1:0]));
    end
    host.send(mkw(2'h3, 1'h1, 2'h3));
    chk("latch0", l0, mkw(2'h0, 1'h0, 2'h0));
    chk("latch1", l1, mkw(2'h0, 1'h0, 2'h1));
    chk("latch2", l2, mkw(2'h0, 1'h0, 2'h2));
  endtask
  task automatic t_power();
    chk("pump", pen, 1'h0);
    ce <= 1'h1;
    repeat (6) @(posedge mclk);
    chk("power", pu, 1'h1);
    chk("pump", pen, 1'h1);
    host.send(mkw(2'h0, 1'h1, 2'h2));
    chk("power", pu, 1'h0);
    host.send(mkw(2'h0, 1'h0, 2'h2));
    chk("power", pu, 1'h1);
    ce <= 1'h0;
    repeat (6) @(posedge mclk);
    chk("pump", pen, 1'h0);
    chk("power", pu, 1'h0);
    host.send(mkw(2'h0, 1'h1, 2'h2));
    ce <= 1'h1;
    repeat (6) @(posedge mclk);
    chk("power", pu, 1'h0);
    chk("pump", pen, 1'h0);
    ce <= 1'h0;
  endtask
  task automatic t_mon();
    logic [2:0] oh;
    for (int m = 0; m < 4; m++)
    begin
      host.send(mkw(m[1:0], 1'h0, 2'h2));
      oh = (m == 3) ? 3'h0 : 3'h1 << m;
      {rf, rfr, lk} <= oh;
      repeat (3) @(posedge mclk);
      chk("monitor", mon, oh != 3'h0);
      {rf, rfr, lk} <= ~oh;
      repeat (3) @(posedge mclk);
      chk("monitor", mon, 1'h0);
    end
  endtask
  initial
  begin
    {rst, ce, rf, rfr, lk} = 5'h10;
    repeat (3) @(posedge mclk);
    rst <= 1'h0;
    repeat (2) @(posedge mclk);
    t_load();
    t_power();
    t_mon();
    stop_test();
  end
  initial
  begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    stop_test();
  end
endmodule
